// ### common/bmad_consts.svh
// bmad_consts.svh: address map, port indices and reset values of the bus matrix decoder
// assumes a 32-bit byte address on every master port
`ifndef BMAD_CONSTS_SVH
`define BMAD_CONSTS_SVH

`define BMAD_NUM_MST        4              // master ports
`define BMAD_NUM_SLV        10             // slave port indices, 7 left unused
`define BMAD_BANK_MSB       31             // bank number sits in the top nibble
`define BMAD_BANK_LSB       28             // 16 banks of 256 MB
`define BMAD_BANK_INT       4'h0           // on-chip memories
`define BMAD_BANK_EXT_FIRST 4'h1           // external chip select zero
`define BMAD_BANK_EXT_LAST  4'h8           // external chip select seven
`define BMAD_BANK_PERIPH    4'hF           // peripheral bridge
`define BMAD_AREA_MSB       27             // 1 MB areas inside bank zero
`define BMAD_AREA_LSB       20
`define BMAD_AREA_BOOT      8'h00          // boot window 0x0 .. 0x000F_FFFF
`define BMAD_AREA_ROM       8'h01          // 0x0010_0000
`define BMAD_AREA_SRAM0     8'h02          // 0x0020_0000
`define BMAD_AREA_SRAM1     8'h03          // 0x0030_0000
`define BMAD_AREA_FPGA_LO   8'h04          // 0x0040_0000 .. 0x007F_FFFF
`define BMAD_AREA_FPGA_HI   8'h07
`define BMAD_SLV_SRAM0      4'h0           // 96 KB SRAM
`define BMAD_SLV_SRAM1      4'h1           // 64 KB SRAM
`define BMAD_SLV_ROM        4'h2           // 256 KB ROM
`define BMAD_SLV_FPGA_A     4'h3           // programmable-logic slaves 3..6
`define BMAD_SLV_UNUSED     4'h7
`define BMAD_SLV_EXT        4'h8           // external memory port
`define BMAD_SLV_BRIDGE     4'h9           // peripheral bridge
`define BMAD_CS_ZERO        3'h0           // boot chip select of the external port
`define BMAD_RST_MASTER     2'h0           // reset owner / last granted
`define BMAD_RST_CNT        8'h00          // reset burst beat count

`endif

// ### common/bmad_pkg.sv
// bmad_pkg: carrier and state types of the bus matrix decoder
// assumes bmad_consts.svh is on the include path
package bmad_pkg;

    // arbitration scheme per slave
    typedef enum logic [0:0] {
        BMAD_ARB_FIXED,
        BMAD_ARB_RR
    } bmad_arb_e;

    // round-robin default (parked) master
    typedef enum logic [1:0] {
        BMAD_DFLT_NONE,
        BMAD_DFLT_LAST,
        BMAD_DFLT_FIXED
    } bmad_dflt_e;

    // request of one master, held until answered
    typedef struct packed {
        logic        valid;   // a beat is requested
        logic [31:0] addr;    // byte address
        logic        write;   // 1 write, 0 read
        logic        more;    // undefined-length burst goes on after this beat
        logic [31:0] wdata;   // write data
    } bmad_mreq_s;

    // answer to one master
    typedef struct packed {
        logic        ready;   // beat ends this cycle
        logic        err;     // beat aborted
        logic [31:0] rdata;   // read data
    } bmad_mrsp_s;

    // request to one slave
    typedef struct packed {
        logic        sel;     // beat presented
        logic [31:0] addr;
        logic        write;
        logic [31:0] wdata;
        logic [1:0]  master;  // owning master
    } bmad_sreq_s;

    // answer from one slave
    typedef struct packed {
        logic        ready;
        logic        err;
        logic [31:0] rdata;
    } bmad_srsp_s;

    // arbitration setup of one slave
    typedef struct packed {
        bmad_arb_e   mode;
        bmad_dflt_e  dflt;
        logic [1:0]  dflt_master;  // used with BMAD_DFLT_FIXED
        logic [7:0]  slot_limit;   // beats before a burst is broken, 0 acts as 1
    } bmad_arbcfg_s;

    // decoder result
    typedef struct packed {
        logic        hit;
        logic [3:0]  slave;
        logic [2:0]  cs;
    } bmad_dec_s;

    // arbiter state of one slave
    typedef struct packed {
        logic        owned;   // a master holds the grant
        logic        hold;    // burst in progress, grant kept between beats
        logic [1:0]  owner;
        logic [1:0]  last;    // last master that finished a grant
        logic [7:0]  cnt;     // beats in the current burst
    } bmad_slv_st_s;

    // whole state of the matrix
    typedef struct packed {
        logic                boot_taken;  // boot-select level captured
        logic                boot_ext;    // boot from external chip select zero
        logic                remap;       // SRAM placed at address zero
        logic [3:0]          err_pend;    // abort answer due next cycle
        bmad_slv_st_s [9:0]  slv;
    } bmad_state_s;

endpackage

// ### hdl/bmad_matrix.sv
// bmad_matrix: four-master, ten-slave-index bus matrix with per-master decoders,
// boot selection, remap, per-slave arbiters and burst breaking
// assumes masters hold a request stable until answered and slaves answer with ready
//
// Functional notes
// [RULE1] sixteen 256 MB banks from top address bits
// [RULE2] bank zero: 1 MB internal memory areas
// [RULE3] banks 1..8 go to external chip selects
// [RULE4] bank fifteen goes to peripheral bridge
// [RULE5] unused banks answer with an abort
// [RULE6] one identical decoder per master port
// [RULE7] masters run concurrently on different slaves
// [RULE8] masters: core, DMA, two logic masters
// [RULE9] fixed slave index assignment, seven unused
// [RULE10] core address zero maps to boot memory
// [RULE11] boot choice sampled at reset, then held
// [RULE12] boot window: internal, external, or remapped slave
// [RULE13] remap places SRAM at address zero
// [RULE14] every slave has its own arbiter
// [RULE15] fixed or round-robin, three default choices
// [RULE16] undefined bursts broken at slot limit
// [RULE17] boot window spans first megabyte
// [RULE18] boot pin low external, high ROM
// [RULE19] reset clears remap
// [RULE20] grant changes only between beats
`timescale 1ns/100ps
`include "bmad_consts.svh"

module bmad_matrix
(
    input  wire  logic                             ref_clk,          // 250 MHz system clock
    input  wire  logic                             rstn,             // async reset, active low
    input  wire  logic                             boot_select_pin,  // boot strap level
    input  wire  logic                             remap_cmd,        // one-cycle remap pulse
    input  wire  bmad_pkg::bmad_arbcfg_s [9:0]     arb_cfg,          // per-slave arbitration
    input  wire  bmad_pkg::bmad_mreq_s   [3:0]     mst_req,          // master requests
    output       bmad_pkg::bmad_mrsp_s   [3:0]     mst_rsp,          // master answers
    output       bmad_pkg::bmad_sreq_s   [9:0]     slv_req,          // slave requests
    input  wire  bmad_pkg::bmad_srsp_s   [9:0]     slv_rsp,          // slave answers
    output       logic                 [7:0]       ext_chip_select,  // bit0 zero .. bit7 seven
    output       logic                             remap_state,      // remap in force
    output       logic                             boot_external     // boot from chip select zero
);

    bmad_pkg::bmad_state_s       st;        // registered state
    bmad_pkg::bmad_state_s       next_st;   // next state
    bmad_pkg::bmad_dec_s   [3:0] dec;       // decoder result per master
    logic                  [9:0] sel;       // slave presented a beat this cycle
    logic                  [9:0] done;      // beat ends on slave this cycle

    // decoder shared by every master port, so all see one address map
    function automatic bmad_pkg::bmad_dec_s decode
    (
        input logic [31:0] addr,
        input logic        boot_ext,
        input logic        remap
    );
        bmad_pkg::bmad_dec_s d;
        logic [3:0]          bank;
        logic [7:0]          area;
        d    = '0;
        bank = addr[`BMAD_BANK_MSB:`BMAD_BANK_LSB];                  // [RULE1]
        area = addr[`BMAD_AREA_MSB:`BMAD_AREA_LSB];                  // [RULE2]
        if (bank == `BMAD_BANK_INT)
        begin
            // second level: 1 MB areas inside bank zero
            if (area == `BMAD_AREA_BOOT)                             // [RULE17]
            begin
                d.hit = 1'b1;
                if (remap)
                    d.slave = `BMAD_SLV_SRAM0;                       // [RULE13]
                else if (boot_ext)
                begin
                    d.slave = `BMAD_SLV_EXT;                         // [RULE12]
                    d.cs    = `BMAD_CS_ZERO;
                end
                else
                    d.slave = `BMAD_SLV_ROM;                         // [RULE10]
            end
            else if (area == `BMAD_AREA_ROM)
            begin
                d.hit   = 1'b1;
                d.slave = `BMAD_SLV_ROM;                             // [RULE9]
            end
            else if (area == `BMAD_AREA_SRAM0)
            begin
                d.hit   = 1'b1;
                d.slave = `BMAD_SLV_SRAM0;
            end
            else if (area == `BMAD_AREA_SRAM1)
            begin
                d.hit   = 1'b1;
                d.slave = `BMAD_SLV_SRAM1;
            end
            else if (area >= `BMAD_AREA_FPGA_LO && area <= `BMAD_AREA_FPGA_HI)
            begin
                d.hit   = 1'b1;
                d.slave = `BMAD_SLV_FPGA_A + 4'(area - `BMAD_AREA_FPGA_LO);
            end
        end
        else if (bank >= `BMAD_BANK_EXT_FIRST && bank <= `BMAD_BANK_EXT_LAST)
        begin
            d.hit   = 1'b1;
            d.slave = `BMAD_SLV_EXT;                                 // [RULE3]
            d.cs    = 3'(bank - `BMAD_BANK_EXT_FIRST);
        end
        else if (bank == `BMAD_BANK_PERIPH)
        begin
            d.hit   = 1'b1;
            d.slave = `BMAD_SLV_BRIDGE;                              // [RULE4]
        end
        // banks 9..14 and spare areas leave hit low: abort [RULE5]
        return d;
    endfunction

    // pick a winner among requesters; fixed favours the lowest master index,
    // round-robin starts the search just after the last master served
    function automatic logic [2:0] arbitrate
    (
        input logic [3:0]          reqs,
        input bmad_pkg::bmad_arb_e mode,
        input logic [1:0]          last
    );
        logic [2:0] win;
        logic [1:0] idx;
        win = '0;
        for (int i = 3; i >= 0; i--)
        begin
            if (mode == bmad_pkg::BMAD_ARB_FIXED)
                idx = 2'(i);                                         // [RULE15]
            else
                idx = 2'(last + 2'(i) + 2'h1);
            // later iterations override, so the last one scanned has priority
            if (reqs[idx])
                win = {1'b1, idx};
        end
        return win;
    endfunction

    // one decoder per master port
    generate
        for (genvar m = 0; m < `BMAD_NUM_MST; m++)  // [RULE8]
        begin : g_dec
            assign dec[m] = decode(mst_req[m].addr, st.boot_ext, st.remap);   // [RULE6]
        end
    endgenerate

    // slave side: the owning master's beat goes through untouched
    always_comb
    begin
        for (int s = 0; s < `BMAD_NUM_SLV; s++)
        begin
            slv_req[s]        = '0;
            slv_req[s].master = st.slv[s].owner;
            slv_req[s].addr   = mst_req[st.slv[s].owner].addr;
            slv_req[s].write  = mst_req[st.slv[s].owner].write;
            slv_req[s].wdata  = mst_req[st.slv[s].owner].wdata;
            sel[s] = st.slv[s].owned && mst_req[st.slv[s].owner].valid
                     && dec[st.slv[s].owner].hit
                     && dec[st.slv[s].owner].slave == 4'(s);
            slv_req[s].sel    = sel[s];
            done[s]           = sel[s] && slv_rsp[s].ready;
        end
    end

    // chip select of the external port follows its owner's decode
    always_comb
    begin
        ext_chip_select = '0;
        if (sel[`BMAD_SLV_EXT])                                      // [RULE3]
            ext_chip_select[dec[st.slv[`BMAD_SLV_EXT].owner].cs] = 1'b1;
    end

    // master side: each master sees only its own slave, so others run freely
    always_comb
    begin
        for (int m = 0; m < `BMAD_NUM_MST; m++)
        begin
            mst_rsp[m] = '0;
            if (st.err_pend[m])
            begin
                mst_rsp[m].ready = 1'b1;                             // [RULE5]
                mst_rsp[m].err   = 1'b1;
            end
            else if (dec[m].hit && sel[dec[m].slave]
                     && st.slv[dec[m].slave].owner == 2'(m))         // [RULE7]
            begin
                mst_rsp[m].ready = slv_rsp[dec[m].slave].ready;
                mst_rsp[m].err   = slv_rsp[dec[m].slave].err;
                mst_rsp[m].rdata = slv_rsp[dec[m].slave].rdata;
            end
        end
    end

    // next-state logic: boot capture, remap, aborts and every slave's arbiter
    always_comb
    begin
        logic [3:0] reqs;
        logic [2:0] win;
        logic [7:0] lim;
        reqs    = '0;
        win     = '0;
        lim     = '0;
        next_st = st;

        // strap taken on the first edge after reset release, then frozen
        if (!st.boot_taken)
        begin
            next_st.boot_taken = 1'b1;                               // [RULE11]
            next_st.boot_ext   = !boot_select_pin;                   // [RULE18]
        end
        if (remap_cmd)
            next_st.remap = 1'b1;                                    // [RULE13]

        // abort answer one cycle after a miss, then cleared
        for (int m = 0; m < `BMAD_NUM_MST; m++)
            next_st.err_pend[m] = !st.err_pend[m] && mst_req[m].valid
                                  && !dec[m].hit;                    // [RULE5]

        // per-slave arbiters, each with its own setup
        for (int s = 0; s < `BMAD_NUM_SLV; s++)                      // [RULE14]
        begin
            for (int m = 0; m < `BMAD_NUM_MST; m++)
                reqs[m] = mst_req[m].valid && dec[m].hit && dec[m].slave == 4'(s);
            win = arbitrate(reqs, arb_cfg[s].mode, st.slv[s].last);
            lim = (arb_cfg[s].slot_limit == 8'h00) ? 8'h01 : arb_cfg[s].slot_limit;

            if (done[s])
            begin
                // beat boundary: keep a burst until the slot limit breaks it
                if (mst_req[st.slv[s].owner].more && (st.slv[s].cnt + 8'h01) < lim)
                begin
                    next_st.slv[s].hold = 1'b1;                      // [RULE16]
                    next_st.slv[s].cnt  = st.slv[s].cnt + 8'h01;
                end
                else
                begin
                    next_st.slv[s].owned = 1'b0;                     // [RULE16]
                    next_st.slv[s].hold  = 1'b0;
                    next_st.slv[s].cnt   = `BMAD_RST_CNT;
                    next_st.slv[s].last  = st.slv[s].owner;
                end
            end
            else if (!sel[s] && !st.slv[s].hold)
            begin
                // no beat in flight: free to regrant or park
                if (win[2])
                begin
                    next_st.slv[s].owned = 1'b1;                     // [RULE20]
                    next_st.slv[s].owner = win[1:0];
                end
                else if (arb_cfg[s].mode == bmad_pkg::BMAD_ARB_FIXED
                         || arb_cfg[s].dflt == bmad_pkg::BMAD_DFLT_NONE)
                    next_st.slv[s].owned = 1'b0;
                else if (arb_cfg[s].dflt == bmad_pkg::BMAD_DFLT_LAST)
                begin
                    next_st.slv[s].owned = 1'b1;                     // [RULE15]
                    next_st.slv[s].owner = st.slv[s].last;
                end
                else
                begin
                    next_st.slv[s].owned = 1'b1;                     // [RULE15]
                    next_st.slv[s].owner = arb_cfg[s].dflt_master;
                end
            end
            // a beat waiting on the slave keeps its grant untouched [RULE20]
        end

        // index seven has no slave behind it and never holds a grant
        next_st.slv[`BMAD_SLV_UNUSED] = '0;
    end

    // state register; reset clears remap and rearms the strap capture
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st            <= '0;                                     // [RULE19]
            st.boot_ext   <= 1'b0;
            st.boot_taken <= 1'b0;
        end
        else
            st <= next_st;
    end

    // status straight from flip-flops
    assign remap_state   = st.remap;
    assign boot_external = st.boot_ext;

endmodule

// ### testbench/bmad_matrix_asserts.sv
// bmad_matrix_asserts: port-level timing and routing checks of the bus matrix
// assumes it is bound onto bmad_matrix; one clock domain, async active-low reset
`timescale 1ns/100ps
module bmad_matrix_asserts
(
    input wire logic                       ref_clk,
    input wire logic                       rstn,
    input wire logic                       boot_select_pin,
    input wire logic                       remap_cmd,
    input wire bmad_pkg::bmad_mreq_s [3:0] mst_req,
    input wire bmad_pkg::bmad_mrsp_s [3:0] mst_rsp,
    input wire bmad_pkg::bmad_sreq_s [9:0] slv_req,
    input wire bmad_pkg::bmad_srsp_s [9:0] slv_rsp,
    input wire logic [7:0]                 ext_chip_select,
    input wire logic                       remap_state,
    input wire logic                       boot_external
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // slot seven has nothing behind it
    a_unused_idle: assert property (!slv_req[7].sel)
        else $error("unused slave selected");
    // only the top bank reaches the bridge
    a_periph_bank: assert property (
        slv_req[9].sel |-> slv_req[9].addr[31:28] == 4'hF)
        else $error("bridge got foreign bank");
    // one chip select per external bank, boot window on select zero
    a_ext_select: assert property (
        slv_req[8].sel |-> ext_chip_select == (slv_req[8].addr[31:28] == 4'h0 ?
        8'h01 : 8'h01 << (slv_req[8].addr[31:28] - 4'h1)))
        else $error("wrong chip select");
    a_ext_quiet: assert property (!slv_req[8].sel |-> ext_chip_select == 8'h00)
        else $error("chip select without access");
    // boot window owners follow strap and remap
    a_rom_boot: assert property (
        slv_req[2].sel && slv_req[2].addr[31:20] == 12'h000 |-> !boot_external && !remap_state)
        else $error("rom at zero out of mode");
    a_sram_remap: assert property (
        slv_req[0].sel && slv_req[0].addr[31:20] == 12'h000 |-> remap_state)
        else $error("sram at zero before remap");
    // remap sticks until the next reset
    a_remap_held: assert property (remap_cmd || remap_state |=> remap_state)
        else $error("remap lost");
    a_reset_clear: assert property ($rose(rstn) |-> !remap_state)
        else $error("remap kept over reset");
    // strap captured once after reset, then frozen
    a_boot_take: assert property (
        $rose(rstn) |=> boot_external == !$past(boot_select_pin))
        else $error("boot strap not captured");
    a_boot_hold: assert property ($past(rstn, 2) |-> $stable(boot_external))
        else $error("boot choice moved");

    genvar m;
    genvar s;
    generate
        for (m = 0; m < 4; m++)
        begin : g_mst
            // unmapped banks abort exactly one cycle after the request rises
            a_abort_next: assert property (
                $rose(mst_req[m].valid) && mst_req[m].addr[31:28] inside {[4'h9:4'hE]}
                |=> mst_rsp[m].ready && mst_rsp[m].err)
                else $error("abort answer late");
        end
        for (s = 0; s < 10; s++)
        begin : g_slv
            // grant cannot move while a beat waits on its slave
            a_grant_held: assert property (
                slv_req[s].sel && !slv_rsp[s].ready
                |=> slv_req[s].sel && $stable(slv_req[s].master))
                else $error("grant moved mid beat");
        end
    endgenerate
endmodule

// ### testbench/bmad_slave_model.sv
// bmad_slave_model: ten behavioural slaves, zero or two wait states each
// assumes requests come straight from the matrix; read data tags the slave index
`timescale 1ns/100ps
module bmad_slave_model
(
    input wire logic                       ref_clk,
    input wire logic                       rstn,
    input wire logic [9:0]                 slow,     // two wait states per slave
    input wire bmad_pkg::bmad_sreq_s [9:0] slv_req,
    output     bmad_pkg::bmad_srsp_s [9:0] slv_rsp
);
    logic [9:0][1:0]  waits;  // wait states spent on the current beat
    logic [9:0][31:0] last;   // last data driven, inverted when idle

    // count waits; remember data so an idle bus never repeats it
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        for (int s = 0; s < 10; s++)
        begin
            if (!rstn)
            begin
                waits[s] <= 2'h0;
                last[s]  <= 32'h0;
            end
            else
            begin
                waits[s] <= (slv_req[s].sel && !slv_rsp[s].ready) ? waits[s] + 2'h1 : 2'h0;
                if (slv_req[s].sel)
                    last[s] <= slv_rsp[s].rdata;
            end
        end
    end

    // answer; released lines show the inverse of the last value
    always_comb
    begin
        for (int s = 0; s < 10; s++)
        begin
            slv_rsp[s].ready = slv_req[s].sel && (!slow[s] || waits[s] == 2'h2);
            slv_rsp[s].err   = 1'b0;
            slv_rsp[s].rdata = slv_req[s].sel ? slv_req[s].addr ^ {4'(s), 28'h5A5A5A5} : ~last[s];
        end
    end
endmodule

// ### testbench/testbench.sv
// testbench: random and directed traffic from four masters through the matrix
// assumes bmad_slave_model answers every slave port
`timescale 1ns/100ps
module testbench;
    logic                       ref_clk = 1'b0;
    logic                       rstn = 1'b0;
    logic                       boot_select_pin = 1'b1;
    logic                       remap_cmd = 1'b0;
    bmad_pkg::bmad_arbcfg_s [9:0] arb_cfg = '0;
    bmad_pkg::bmad_mreq_s [3:0] mst_req = '0;
    bmad_pkg::bmad_mrsp_s [3:0] mst_rsp;
    bmad_pkg::bmad_sreq_s [9:0] slv_req;
    bmad_pkg::bmad_srsp_s [9:0] slv_rsp;
    logic [7:0]                 ext_chip_select;
    logic                       remap_state;
    logic                       boot_external;
    logic [9:0]                 slow = '0;
    logic                       exp_remap = 1'b0;  // bench view of remap
    logic                       exp_bootx = 1'b0;  // bench view of boot choice
    int                         mismatches = 0;
    int                         n_compared = 0;
    int                         lat;               // edges waited by the last beat
    time                        t_done [4];

    always #2 ref_clk = ~ref_clk;

    bmad_matrix DUT (.ref_clk(ref_clk), .rstn(rstn), .boot_select_pin(boot_select_pin),
        .remap_cmd(remap_cmd), .arb_cfg(arb_cfg), .mst_req(mst_req), .mst_rsp(mst_rsp),
        .slv_req(slv_req), .slv_rsp(slv_rsp), .ext_chip_select(ext_chip_select),
        .remap_state(remap_state), .boot_external(boot_external));
    bmad_slave_model u_slv (.ref_clk(ref_clk), .rstn(rstn), .slow(slow), .slv_req(slv_req),
        .slv_rsp(slv_rsp));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // expected slave from the address map, 7 meaning abort
    function automatic logic [3:0] exp_slave(input logic [31:0] a);
        if (a[31:28] == 4'h0)
        begin
            if (a[27:20] == 8'h00)
                return exp_remap ? 4'h0 : (exp_bootx ? 4'h8 : 4'h2);
            if (a[27:20] inside {[8'h04:8'h07]})
                return a[23:20] - 4'h1;
            return a[27:20] == 8'h01 ? 4'h2 : a[27:20] == 8'h02 ? 4'h0 :
                   a[27:20] == 8'h03 ? 4'h1 : 4'h7;
        end
        return a[31:28] <= 4'h8 ? 4'h8 : a[31:28] == 4'hF ? 4'h9 : 4'h7;
    endfunction

    // one beat; more keeps valid up for the next beat of a burst
    task automatic beat(input int m, input logic [31:0] a, input logic w, input logic mr);
        logic [3:0] s;
        s = exp_slave(a);
        @(negedge ref_clk);
        mst_req[m].valid = 1'b1;
        mst_req[m].addr = a;
        mst_req[m].write = w;
        mst_req[m].more = mr;
        mst_req[m].wdata = $urandom();
        lat = 0;
        @(posedge ref_clk);
        while (mst_rsp[m].ready !== 1'b1 && lat < 200)
        begin
            @(posedge ref_clk);
            lat++;
        end
        t_done[m] = $time;
        check(lat < 200, 1'b1);
        check(mst_rsp[m].err, s == 4'h7);
        if (s != 4'h7)
            check({slv_req[s].sel, slv_req[s].master}, {1'b1, 2'(m)});
        if (s != 4'h7)
            check(slv_req[s].wdata, mst_req[m].wdata);
        if (s != 4'h7)
            check(slv_req[s].write, w);
        if (s != 4'h7 && !w)
            check(mst_rsp[m].rdata, a ^ {s, 28'h5A5A5A5});
        if (s == 4'h8)
            check(ext_chip_select, a[31:28] == 4'h0 ? 8'h01 : 8'h01 << (a[31:28] - 4'h1));
        if (!mr)
        begin
            @(negedge ref_clk);
            mst_req[m].valid = 1'b0;
        end
    endtask

    task automatic do_reset(input logic pin);
        @(negedge ref_clk);
        rstn = 1'b0;
        boot_select_pin = pin;
        repeat (20) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (2) @(negedge ref_clk);
        exp_bootx = !pin;
        exp_remap = 1'b0;
        check({remap_state, boot_external}, {1'b0, !pin});
    endtask

    initial
    begin
        void'($urandom(76084));
        do_reset(1'b1);
        arb_cfg[1].mode = bmad_pkg::BMAD_ARB_RR;
        // fixed slave 0 and round-robin slave 1 contended at once
        fork
            beat(0, 32'h0020_0000, 1'b0, 1'b0);
            beat(3, 32'h0020_0004, 1'b0, 1'b0);
            beat(1, 32'h0030_0000, 1'b0, 1'b0);
            beat(2, 32'h0030_0004, 1'b1, 1'b0);
        join
        check(t_done[0] == t_done[1], 1'b1);
        check(t_done[0] < t_done[3], 1'b1);
        check(t_done[1] < t_done[2], 1'b1);
        fork
            beat(2, 32'h0030_0008, 1'b0, 1'b0);
            beat(3, 32'h0030_000C, 1'b0, 1'b0);
        join
        check(t_done[3] < t_done[2], 1'b1);
        // default master choices: parked owner answers with no arbitration cycle
        for (int d = 0; d < 3; d++)
        begin
            arb_cfg[3] = {bmad_pkg::BMAD_ARB_RR, 2'(d), 2'h2, 8'h01};
            beat(2, 32'h0040_0000, 1'b0, 1'b0);
            beat(2, 32'h0040_0004, 1'b0, 1'b0);
            check(lat, d == 0 ? 1 : 0);
        end
        // slot limit two breaks a four-beat burst for a waiting master
        arb_cfg[4] = {bmad_pkg::BMAD_ARB_RR, bmad_pkg::BMAD_DFLT_NONE, 2'h0, 8'h02};
        slow[4] = 1'b1;
        fork
            for (int i = 0; i < 4; i++)
                beat(1, 32'h0050_0000 + 32'(i * 4), 1'b0, i < 3);
            beat(0, 32'h0050_0100, 1'b0, 1'b0);
        join
        check(t_done[0] < t_done[1], 1'b1);
        slow = 10'h3FF;
        // every bank once, then random traffic from all masters
        for (int b = 0; b < 16; b++)
            beat(b % 4, {4'(b), 28'h0000010}, 1'b0, 1'b0);
        repeat (80)
            beat($urandom_range(0, 3), {4'($urandom_range(0, 15)), 8'($urandom_range(0, 8)),
                18'($urandom()), 2'h0}, 1'($urandom()), 1'b0);
        // remap pulse moves SRAM to zero, checked for master one
        @(negedge ref_clk);
        remap_cmd = 1'b1;
        @(negedge ref_clk);
        remap_cmd = 1'b0;
        exp_remap = 1'b1;
        check(remap_state, 1'b1);
        beat(1, 32'h0000_0040, 1'b0, 1'b0);
        // low strap boots from chip select zero and clears remap
        do_reset(1'b0);
        beat(0, 32'h0000_0080, 1'b0, 1'b0);
        report_and_stop();
    end

    initial
    begin
        #200000;
        mismatches++;
        report_and_stop();
    end
endmodule

bind bmad_matrix bmad_matrix_asserts u_chk (.ref_clk(ref_clk), .rstn(rstn),
    .boot_select_pin(boot_select_pin), .remap_cmd(remap_cmd), .mst_req(mst_req),
    .mst_rsp(mst_rsp), .slv_req(slv_req), .slv_rsp(slv_rsp),
    .ext_chip_select(ext_chip_select), .remap_state(remap_state),
    .boot_external(boot_external));
